// >>> rtl/wdrf_map.vh
// constants and summary for the watchdog and recovery-frequency block
// Summary of operation
// - Recovery source select 0: recovery frequency comes from latched strap code.
// - Recovery source select 1: timeout switches CPU to recovery N/M dividers.
// - Ratio follows latched strap when override clear, programmed ratio field when set.
// - Writing either recovery divider byte starts a new load immediately.
// - Run control 0 stops the counter and reloads the timeout value.
// - Run control 1 counts down only after an output frequency change.
// - Expired flag reads 0 without timeout; writing 0 does nothing.
// - Expired flag reads 1 after timeout; writing 1 clears it.
// - Counter reaching zero sets the expired flag.
// - Five-bit timeout count holds the timeout in selected time units.
// - Unit select 0 picks 150 ms, spanning 150 ms to 4.8 s.
// - The 2.5 s unit spans 2.5 s to 80 s.
`ifndef WDRF_MAP_VH
`define WDRF_MAP_VH

// ==========================================================
// clock and time units
`define WDRF_CLK_KHZ 50000
`define WDRF_UNIT_SHORT_MS 150
`define WDRF_UNIT_LONG_MS 2500
`define WDRF_UNIT_SHORT_CYC (`WDRF_UNIT_SHORT_MS * `WDRF_CLK_KHZ)
`define WDRF_UNIT_LONG_CYC (`WDRF_UNIT_LONG_MS * `WDRF_CLK_KHZ)
`define WDRF_UNIT_SEL_SHORT 1'b0
`define WDRF_UNIT_SEL_LONG 1'b1

// ==========================================================
// field widths and reset values
`define WDRF_DIV_N_W 8
`define WDRF_DIV_M_W 7
`define WDRF_CODE_W 5
`define WDRF_CNT_W 6
`define WDRF_DIV_N_RST 8'h00
`define WDRF_DIV_M_RST 7'h00
`define WDRF_CODE_RST 5'h00
`define WDRF_COUNT_ZERO_UNITS 6'h20

// ==========================================================
// watchdog states
`define WDRF_ST_STOP 2'h0
`define WDRF_ST_ARMED 2'h1
`define WDRF_ST_COUNT 2'h2
`define WDRF_ST_DONE 2'h3

`endif

// >>> rtl/wdrf_tick.v
// time-unit tick generator for the watchdog counter
`include "wdrf_map.vh"

module wdrf_tick #(
	parameter integer SHORT_CYCLES = `WDRF_UNIT_SHORT_CYC,
	parameter integer LONG_CYCLES = `WDRF_UNIT_LONG_CYC
) (
	// clock and reset
	input wire ref_clk,
	input wire reset,
	// control
	input wire restart,
	input wire run,
	input wire unit_long,
	// result
	output reg tick
);

	// ==========================================================
	// unit counter
	reg [31:0] cnt_q;
	wire [31:0] last_w;

	// unit select 0 is the short unit, 1 the long unit
	assign last_w = unit_long ? LONG_CYCLES - 1 : SHORT_CYCLES - 1;

	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cnt_q <= 32'h00000000;
			tick <= 1'b0;
		end else if (restart || !run) begin
			cnt_q <= 32'h00000000;
			tick <= 1'b0;
		end else if (cnt_q >= last_w) begin
			cnt_q <= 32'h00000000;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 32'h00000001;
			tick <= 1'b0;
		end
	end

endmodule

// >>> rtl/wdrf_top.v
// watchdog timer and recovery-frequency selection
`include "wdrf_map.vh"

module wdrf_top #(
	parameter integer SHORT_CYCLES = `WDRF_UNIT_SHORT_CYC,
	parameter integer LONG_CYCLES = `WDRF_UNIT_LONG_CYC
) (
	// clock and reset
	input wire ref_clk,
	input wire reset,
	// strap pins
	input wire [4:0] strap_frequency_code,
	// control byte bits
	input wire recovery_source_select,
	input wire strap_ratio_override,
	input wire [4:0] ratio_select,
	input wire watchdog_run_control,
	input wire watchdog_time_unit,
	input wire [4:0] watchdog_timeout_count,
	// recovery divider byte writes
	input wire n_wr_stb,
	input wire [7:0] n_wr_data,
	input wire m_wr_stb,
	input wire [6:0] m_wr_data,
	// expired flag write
	input wire flag_wr_stb,
	input wire flag_wr_data,
	// frequency change event from the programmed-frequency logic
	input wire freq_change,
	// register readback
	output reg [7:0] recovery_divider_n,
	output reg [6:0] recovery_divider_m,
	output reg watchdog_expired_flag,
	output reg [5:0] watchdog_count_now,
	// latched strap and ratio
	output reg [4:0] strap_latched,
	output reg [4:0] ratio_code,
	// recovery frequency towards the synthesizer
	output reg recovery_load,
	output reg recovery_switch,
	output reg recovery_use_dividers,
	output reg [7:0] recovery_n_out,
	output reg [6:0] recovery_m_out,
	output reg [4:0] recovery_strap_out
);

	// ==========================================================
	// strap latch, caught on the first edge after reset release
	reg strap_taken_q;

	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			strap_taken_q <= 1'b0;
			strap_latched <= `WDRF_CODE_RST;
		end else if (!strap_taken_q) begin
			strap_taken_q <= 1'b1;
			strap_latched <= strap_frequency_code;
		end
	end

	// ==========================================================
	// ratio select
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ratio_code <= `WDRF_CODE_RST;
		end else if (strap_ratio_override) begin
			ratio_code <= ratio_select;
		end else begin
			ratio_code <= strap_latched;
		end
	end

	// ==========================================================
	// recovery divider registers
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			recovery_divider_n <= `WDRF_DIV_N_RST;
			recovery_divider_m <= `WDRF_DIV_M_RST;
			recovery_load <= 1'b0;
		end else begin
			if (n_wr_stb) begin
				recovery_divider_n <= n_wr_data;
			end
			if (m_wr_stb) begin
				recovery_divider_m <= m_wr_data;
			end
			// each byte write loads on its own, without waiting for the other
			recovery_load <= n_wr_stb | m_wr_stb;
		end
	end

	// ==========================================================
	// timeout reload value: code 0 stands for 32 units
	wire [5:0] reload_w;

	assign reload_w = (watchdog_timeout_count == 5'h00) ? `WDRF_COUNT_ZERO_UNITS :
		{1'b0, watchdog_timeout_count};

	// ==========================================================
	// unit tick
	wire tick_w;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg tick_restart;

	wdrf_tick #(
		.SHORT_CYCLES(SHORT_CYCLES),
		.LONG_CYCLES(LONG_CYCLES)
	) u_tick (
		.ref_clk(ref_clk),
		.reset(reset),
		.restart(tick_restart),
		.run(state_q == `WDRF_ST_COUNT),
		.unit_long(watchdog_time_unit),
		.tick(tick_w)
	);

	// ==========================================================
	// watchdog state machine
	reg [5:0] count_d;
	reg expire_w;

	always @* begin
		state_d = state_q;
		count_d = watchdog_count_now;
		tick_restart = 1'b0;
		expire_w = 1'b0;
		case (state_q)
			`WDRF_ST_STOP: begin
				count_d = reload_w;
				if (watchdog_run_control) begin
					state_d = `WDRF_ST_ARMED;
				end
			end
			`WDRF_ST_ARMED: begin
				count_d = reload_w;
				if (freq_change) begin
					state_d = `WDRF_ST_COUNT;
					tick_restart = 1'b1;
				end
			end
			`WDRF_ST_COUNT: begin
				if (freq_change) begin
					count_d = reload_w;
					tick_restart = 1'b1;
				end else if (tick_w) begin
					count_d = watchdog_count_now - 6'h01;
					if (watchdog_count_now == 6'h01) begin
						state_d = `WDRF_ST_DONE;
						expire_w = 1'b1;
					end
				end
			end
			`WDRF_ST_DONE: begin
				count_d = 6'h00;
			end
			default: begin
				state_d = `WDRF_ST_STOP;
				count_d = reload_w;
			end
		endcase
		if (!watchdog_run_control) begin
			state_d = `WDRF_ST_STOP;
			count_d = reload_w;
			tick_restart = 1'b1;
			expire_w = 1'b0;
		end
	end

	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_q <= `WDRF_ST_STOP;
			watchdog_count_now <= `WDRF_COUNT_ZERO_UNITS;
		end else begin
			state_q <= state_d;
			watchdog_count_now <= count_d;
		end
	end

	// ==========================================================
	// expired flag: a timeout in the clearing cycle wins
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			watchdog_expired_flag <= 1'b0;
		end else if (expire_w) begin
			watchdog_expired_flag <= 1'b1;
		end else if (flag_wr_stb && flag_wr_data) begin
			watchdog_expired_flag <= 1'b0;
		end
	end

	// ==========================================================
	// recovery frequency selection on timeout
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			recovery_switch <= 1'b0;
			recovery_use_dividers <= 1'b0;
			recovery_n_out <= `WDRF_DIV_N_RST;
			recovery_m_out <= `WDRF_DIV_M_RST;
			recovery_strap_out <= `WDRF_CODE_RST;
		end else begin
			recovery_switch <= expire_w;
			if (expire_w) begin
				recovery_use_dividers <= recovery_source_select;
				recovery_n_out <= recovery_divider_n;
				recovery_m_out <= recovery_divider_m;
				recovery_strap_out <= strap_latched;
			end
		end
	end

endmodule

// >>> dv/wdrf_assertions.sv
// port checker for the watchdog and recovery-frequency block
module wdrf_assertions (
	// clock and reset
	input wire ref_clk,
	input wire reset,
	// inputs
	input wire recovery_source_select,
	input wire strap_ratio_override,
	input wire [4:0] ratio_select,
	input wire watchdog_run_control,
	input wire [4:0] watchdog_timeout_count,
	input wire n_wr_stb,
	input wire [7:0] n_wr_data,
	input wire m_wr_stb,
	input wire flag_wr_stb,
	input wire flag_wr_data,
	// outputs
	input wire [7:0] recovery_divider_n,
	input wire watchdog_expired_flag,
	input wire [5:0] watchdog_count_now,
	input wire [4:0] strap_latched,
	input wire [4:0] ratio_code,
	input wire recovery_load,
	input wire recovery_switch,
	input wire recovery_use_dividers,
	input wire [7:0] recovery_n_out,
	input wire [4:0] recovery_strap_out
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	sequence stopped_s;
		!watchdog_run_control ##1 !watchdog_run_control;
	endsequence
	sequence expiry_s;
		$rose(recovery_switch);
	endsequence
	load_pulse_a: assert property ((n_wr_stb || m_wr_stb) |=> recovery_load)
		else $error("no load pulse");
	n_store_a: assert property (n_wr_stb |=> recovery_divider_n == $past(n_wr_data))
		else $error("divider n not stored");
	flag_clear_a: assert property (flag_wr_stb && flag_wr_data |=> !watchdog_expired_flag || recovery_switch)
		else $error("flag not cleared");
	flag_keep_a: assert property (flag_wr_stb && !flag_wr_data && watchdog_expired_flag |=> watchdog_expired_flag)
		else $error("flag lost on zero write");
	stop_reload_a: assert property (stopped_s |-> watchdog_count_now == ($past(watchdog_timeout_count) == 5'h00 ? 6'h20 : {1'b0, $past(watchdog_timeout_count)}))
		else $error("count not reloaded");
	expiry_flag_a: assert property (expiry_s |-> watchdog_expired_flag && watchdog_count_now == 6'h00)
		else $error("expiry without flag");
	source_pick_a: assert property (expiry_s |-> recovery_use_dividers == $past(recovery_source_select))
		else $error("wrong recovery source");
	strap_source_a: assert property (expiry_s and !recovery_use_dividers |-> recovery_strap_out == strap_latched)
		else $error("wrong strap recovery");
	divider_source_a: assert property (expiry_s and recovery_use_dividers |-> recovery_n_out == $past(recovery_divider_n))
		else $error("wrong divider recovery");
	ratio_follow_a: assert property (!$past(reset) |-> ratio_code == ($past(strap_ratio_override) ? $past(ratio_select) : $past(strap_latched)))
		else $error("wrong ratio");
endmodule

// >>> dv/wdrf_host.sv
// host controller model that writes divider bytes and the expired flag
module wdrf_host (
	input wire ref_clk,
	output logic n_wr_stb, m_wr_stb, flag_wr_stb, flag_wr_data,
	output logic [7:0] n_wr_data,
	output logic [6:0] m_wr_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {n_wr_stb, m_wr_stb, flag_wr_stb, flag_wr_data, n_wr_data, m_wr_data} = '0;
	// one write cycle, enables n/m/flag; released data shows its inverse
	task automatic wr(input logic [2:0] en, input logic [7:0] n, input logic [6:0] m, input logic f);
		@(posedge ref_clk) #1;
		{n_wr_stb, m_wr_stb, flag_wr_stb} = en;
		{n_wr_data, m_wr_data, flag_wr_data} = {n, m, f};
		@(posedge ref_clk) #1;
		{n_wr_stb, m_wr_stb, flag_wr_stb} = 3'h0;
		{n_wr_data, m_wr_data, flag_wr_data} = ~{n, m, f};
	endtask
endmodule

// >>> dv/wdrf_top_bench.sv
// self-checking bench for the watchdog and recovery-frequency block
module wdrf_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SC = 4;
	localparam int LC = 8;
	logic ref_clk = 0;
	logic reset = 1;
	logic [4:0] strap_frequency_code = 5'h15;
	logic [4:0] ratio_select = 5'h0A;
	logic [4:0] watchdog_timeout_count = 5'h01;
	logic recovery_source_select = 0;
	logic strap_ratio_override = 0;
	logic watchdog_run_control = 0;
	logic watchdog_time_unit = 0;
	logic freq_change = 0;
	wire n_wr_stb, m_wr_stb, flag_wr_stb, flag_wr_data;
	wire [7:0] n_wr_data, recovery_divider_n, recovery_n_out;
	wire [6:0] m_wr_data, recovery_divider_m, recovery_m_out;
	wire [5:0] watchdog_count_now;
	wire [4:0] strap_latched, ratio_code, recovery_strap_out;
	wire watchdog_expired_flag, recovery_load, recovery_switch, recovery_use_dividers;
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;
	wdrf_top #(.SHORT_CYCLES(SC), .LONG_CYCLES(LC)) u_dut (.*);
	wdrf_host u_host (.*);
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			test_done();
		end
	end
	// ==========================================================
	// helpers
	task automatic test_done;
		if (n_errors == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] exp, got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_div;
		u_host.wr(3'h4, 8'hA5, 7'h11, 0);
		chk("load n", 1, recovery_load);
		chk("div n", 8'hA5, recovery_divider_n);
		u_host.wr(3'h2, 8'h00, 7'h33, 0);
		chk("load m", 1, recovery_load);
		chk("div m", 7'h33, recovery_divider_m);
		u_host.wr(3'h6, 8'h3C, 7'h5A, 0);
		chk("div nm", {8'h3C, 7'h5A}, {recovery_divider_n, recovery_divider_m});
	endtask
	task automatic t_ratio;
		strap_frequency_code = 5'h03;
		step(2);
		chk("ratio strap", 5'h15, ratio_code);
		strap_ratio_override = 1;
		step(2);
		chk("ratio prog", 5'h0A, ratio_code);
		strap_ratio_override = 0;
	endtask
	task automatic t_wd(input logic s, u, input logic [4:0] c);
		int lim;
		int n;
		lim = (c == 0 ? 32 : c) * (u ? LC : SC);
		recovery_source_select = s;
		watchdog_time_unit = u;
		watchdog_timeout_count = c;
		watchdog_run_control = 1;
		step(12);
		chk("flag idle", 0, watchdog_expired_flag);
		chk("armed", c == 0 ? 32 : c, watchdog_count_now);
		freq_change = 1;
		step(1);
		freq_change = 0;
		for (n = 1; n < lim + 10 && recovery_switch !== 1; n++) step(1);
		chk("timeout", 1, n > lim && n <= lim + 5);
		chk("flag set", 1, watchdog_expired_flag);
		chk("source", s, recovery_use_dividers);
		chk("rec value", s ? 8'h3C : 5'h15, s ? recovery_n_out : recovery_strap_out);
		chk("rec m", 7'h5A, recovery_m_out);
		u_host.wr(3'h1, 0, 0, 0);
		chk("flag kept", 1, watchdog_expired_flag);
		u_host.wr(3'h1, 0, 0, 1);
		chk("flag clear", 0, watchdog_expired_flag);
		watchdog_run_control = 0;
		step(2);
		chk("reload", c == 0 ? 32 : c, watchdog_count_now);
	endtask
	initial begin
		repeat (10) @(posedge ref_clk);
		#1 reset = 0;
		step(3);
		t_div();
		t_ratio();
		t_wd(0, 0, 5'h01);
		t_wd(1, 1, 5'h00);
		t_wd(1, 0, 5'h1F);
		test_done();
	end
endmodule
bind wdrf_top wdrf_assertions u_chk (.*);
